// >>> rtl/uph_regs.svh
// uph_regs.svh: constants of the udp packet header builder.
// assumes byte-wide ethernet mac streams and one clock domain.
`ifndef UPH_REGS_SVH
`define UPH_REGS_SVH
`define UPH_HDR_BYTES 42
`define UPH_MAC_BYTES 14
`define UPH_IP_FIRST 14
`define UPH_IP_LAST 33
`define UPH_IP_CSUM_HI 24
`define UPH_IP_CSUM_LO 25
`define UPH_UDP_LEN_HI 38
`define UPH_UDP_LEN_LO 39
`define UPH_UDP_CSUM_HI 40
`define UPH_UDP_CSUM_LO 41
`define UPH_DPORT_HI 36
`define UPH_DPORT_LO 37
`define UPH_IP_TLEN_HI 16
`define UPH_IP_TLEN_LO 17
`define UPH_CMD_PKT_BYTES 49
`define UPH_RSP_PKT_BYTES 60
`define UPH_STR_PKT_BYTES 557
`define UPH_DEV_CMD_PORT 16'hD6D8
`define UPH_DEV_STR_PORT 16'hDAC0
`define UPH_HOST_CMD_PORT 16'h8C35
`define UPH_HOST_STR_PORT 16'h8CA0
`define UPH_ETH_TYPE_IPV4 16'h0800
`define UPH_IP_VER_IHL 8'h45
`define UPH_IP_TTL 8'h40
`define UPH_IP_PROTO_UDP 8'h11
`define UPH_IP_FLAGS_FRAG 16'h4000
`define UPH_UDP_HDR_BYTES 8
`define UPH_IP_HDR_BYTES 20
`endif

// >>> rtl/uph_pkg.sv
// uph_pkg.sv: types of the udp packet header builder.
// assumes uph_regs.svh is on the include path.
`default_nettype none
package uph_pkg;
  typedef struct packed {
    logic valid;
    logic last;
    logic [7:0] data;
  } uph_byte_t;
  typedef enum logic [3:0] {
    TX_IDLE = 4'b0001,
    TX_SUM = 4'b0010,
    TX_HDR = 4'b0100,
    TX_PAY = 4'b1000
  } uph_tx_state_t;
  typedef enum logic [1:0] {
    SRC_RSP = 2'b01,
    SRC_STR = 2'b10
  } uph_src_t;
endpackage : uph_pkg
`default_nettype wire

// >>> rtl/uph_packet_header_builder.sv
// uph_packet_header_builder.sv: frames responses and stream data with
// fixed mac/ip/udp headers and strips headers from incoming frames.
// assumes a byte-wide mac that accepts one byte per cycle when ready.
`timescale 1ns/1ps
`default_nettype none
`include "uph_regs.svh"
module uph_packet_header_builder
  import uph_pkg::*;
#(
  parameter int RSP_PAY = `UPH_RSP_PKT_BYTES - `UPH_HDR_BYTES,
  parameter int STR_PAY = `UPH_STR_PKT_BYTES - `UPH_HDR_BYTES,
  parameter logic [47:0] DEV_MAC = 48'h0200_0000_0001,
  parameter logic [47:0] HOST_MAC = 48'h0200_0000_0002,
  parameter logic [31:0] DEV_IP = 32'hC0A8_0001,
  parameter logic [31:0] HOST_IP = 32'hC0A8_0002
)(
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire uph_byte_t rsp_in,
  output logic rsp_ready_out,
  input wire uph_byte_t str_in,
  output logic str_ready_out,
  output uph_byte_t mac_tx_out,
  input wire logic mac_tx_ready_in,
  input wire uph_byte_t mac_rx_in,
  output uph_byte_t cmd_out,
  output uph_byte_t sdata_out
);
  // the payload counter is ten bits wide, so 1024 bytes is the ceiling
  if (RSP_PAY < 1 || STR_PAY < 1 || RSP_PAY > 1024 || STR_PAY > 1024)
  begin : gen_bad_payload
    $error("payload length out of range");
  end

  // fixed header table; length and port fields are overlaid per source, checksum fields left zero
  function automatic logic [7:0] hdr_byte(input logic [5:0] idx,
                                          input logic [15:0] plen,
                                          input logic [15:0] sport,
                                          input logic [15:0] dport);
    logic [335:0] h;
    logic [15:0] ip_len;
    logic [15:0] udp_len;
    ip_len = plen + 16'(`UPH_IP_HDR_BYTES + `UPH_UDP_HDR_BYTES);
    udp_len = plen + 16'(`UPH_UDP_HDR_BYTES);
    h = {HOST_MAC, DEV_MAC, `UPH_ETH_TYPE_IPV4,
         `UPH_IP_VER_IHL, 8'h00, ip_len, 16'h0000,
         `UPH_IP_FLAGS_FRAG, `UPH_IP_TTL, `UPH_IP_PROTO_UDP,
         16'h0000,
         DEV_IP, HOST_IP,
         sport, dport, udp_len, 16'h0000};
    hdr_byte = h[335 - 8 * int'(idx) -: 8];
  endfunction : hdr_byte

  uph_tx_state_t state, next_state;
  uph_src_t src, next_src;
  logic [5:0] idx, next_idx;
  logic [9:0] cnt, next_cnt;
  logic [19:0] acc, next_acc;
  logic [15:0] csum, next_csum;
  uph_byte_t tx, next_tx;
  logic rsp_rdy, next_rsp_rdy, str_rdy, next_str_rdy;
  logic [15:0] plen, sport, dport;
  logic [7:0] hb;
  logic [15:0] fold;
  logic [16:0] fold_once;

  assign plen = (src == SRC_RSP) ? 16'(RSP_PAY) : 16'(STR_PAY);
  assign sport = (src == SRC_RSP) ? `UPH_DEV_CMD_PORT : `UPH_DEV_STR_PORT;
  assign dport = (src == SRC_RSP) ? `UPH_HOST_CMD_PORT : `UPH_HOST_STR_PORT;
  assign hb = hdr_byte(idx, plen, sport, dport);
  // adding the carries back can carry once more, so fold twice
  assign fold_once = {1'b0, acc[15:0]} + 17'(acc[19:16]);
  assign fold = fold_once[15:0] + 16'(fold_once[16]);

  always_comb
  begin
    next_state = state;
    next_src = src;
    next_idx = idx;
    next_cnt = cnt;
    next_acc = acc;
    next_csum = csum;
    next_tx = tx;
    next_rsp_rdy = 1'b0;
    next_str_rdy = 1'b0;
    if (tx.valid && mac_tx_ready_in)
      next_tx.valid = 1'b0;
    unique case (state)
      TX_IDLE:
      begin
        next_idx = 6'(`UPH_IP_FIRST);
        next_acc = '0;
        if (rsp_in.valid)
        begin
          next_src = SRC_RSP;
          next_state = TX_SUM;
        end
        else if (str_in.valid)
        begin
          next_src = SRC_STR;
          next_state = TX_SUM;
        end
      end
      TX_SUM:
      begin
        // one header word per cycle, checksum word skipped
        if (idx != 6'(`UPH_IP_CSUM_HI))
          next_acc = acc + 20'({hb, hdr_byte(idx + 6'd1, plen, sport, dport)});
        next_idx = idx + 6'd2;
        if (idx == 6'(`UPH_IP_LAST - 1))
        begin
          next_idx = '0;
          next_state = TX_HDR;
        end
      end
      TX_HDR:
      begin
        if (idx == 6'(`UPH_IP_FIRST))
          next_csum = ~fold;
        if (!tx.valid || mac_tx_ready_in)
        begin
          next_tx.valid = 1'b1;
          next_tx.last = 1'b0;
          if (idx == 6'(`UPH_IP_CSUM_HI))
            next_tx.data = next_csum[15:8];
          else if (idx == 6'(`UPH_IP_CSUM_LO))
            next_tx.data = csum[7:0];
          else
            next_tx.data = hb;
          next_idx = idx + 6'd1;
          if (idx == 6'(`UPH_HDR_BYTES - 1))
          begin
            next_cnt = '0;
            next_state = TX_PAY;
          end
        end
      end
      TX_PAY:
      begin
        // pull a payload byte only when the output slot frees up
        if ((!tx.valid || mac_tx_ready_in) && !rsp_rdy && !str_rdy)
        begin
          if (src == SRC_RSP)
            next_rsp_rdy = 1'b1;
          else
            next_str_rdy = 1'b1;
        end
        if ((rsp_rdy && rsp_in.valid) || (str_rdy && str_in.valid))
        begin
          next_tx.valid = 1'b1;
          next_tx.data = rsp_rdy ? rsp_in.data : str_in.data;
          next_cnt = cnt + 10'd1;
          next_tx.last = (cnt == 10'(plen - 16'd1));
          if (cnt == 10'(plen - 16'd1))
            next_state = TX_IDLE;
        end
        else if (rsp_rdy || str_rdy)
        begin
          next_rsp_rdy = rsp_rdy;
          next_str_rdy = str_rdy;
        end
      end
      default:
        next_state = TX_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state <= TX_IDLE;
      src <= SRC_RSP;
      idx <= '0;
      cnt <= '0;
      acc <= '0;
      csum <= '0;
      tx <= '0;
      rsp_rdy <= 1'b0;
      str_rdy <= 1'b0;
    end
    else
    begin
      state <= next_state;
      src <= next_src;
      idx <= next_idx;
      cnt <= next_cnt;
      acc <= next_acc;
      csum <= next_csum;
      tx <= next_tx;
      rsp_rdy <= next_rsp_rdy;
      str_rdy <= next_str_rdy;
    end
  end

  assign mac_tx_out = tx;
  assign rsp_ready_out = rsp_rdy;
  assign str_ready_out = str_rdy;

  // receive side: count header bytes, capture port, forward payload
  logic [5:0] rx_idx, next_rx_idx;
  logic [15:0] rx_port, next_rx_port;
  uph_byte_t cmd, next_cmd, sdat, next_sdat;
  logic is_cmd, is_str;

  assign is_cmd = (rx_port == `UPH_DEV_CMD_PORT);
  assign is_str = (rx_port == `UPH_DEV_STR_PORT);

  always_comb
  begin
    next_rx_idx = rx_idx;
    next_rx_port = rx_port;
    next_cmd = '0;
    next_sdat = '0;
    if (mac_rx_in.valid)
    begin
      if (rx_idx != 6'(`UPH_HDR_BYTES))
      begin
        next_rx_idx = rx_idx + 6'd1;
        if (rx_idx == 6'(`UPH_DPORT_HI))
          next_rx_port[15:8] = mac_rx_in.data;
        if (rx_idx == 6'(`UPH_DPORT_LO))
          next_rx_port[7:0] = mac_rx_in.data;
      end
      else
      begin
        next_cmd = is_cmd ? mac_rx_in : '0;
        next_sdat = is_str ? mac_rx_in : '0;
      end
      // a short frame ending inside the header is dropped
      if (mac_rx_in.last)
        next_rx_idx = '0;
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rx_idx <= '0;
      rx_port <= '0;
      cmd <= '0;
      sdat <= '0;
    end
    else
    begin
      rx_idx <= next_rx_idx;
      rx_port <= next_rx_port;
      cmd <= next_cmd;
      sdat <= next_sdat;
    end
  end

  assign cmd_out = cmd;
  assign sdata_out = sdat;
endmodule : uph_packet_header_builder
`default_nettype wire

// >>> tb/uph_mac_model.sv
// mac model: accepts tx bytes with random stalls.
// assumes one clock shared with the framer.
`timescale 1ns/1ps
`default_nettype none
module uph_mac_model
  import uph_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire uph_byte_t tx_in,
  output logic ready_out
);
  int s = 12;
  // stalls a quarter of cycles so held bytes get exercised
  always @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      ready_out <= 1'b0;
    else
      // one idle cycle after each frame's last byte, as a frame gap
      ready_out <= (($random(s) % 4) != 0)
        && !(tx_in.valid && tx_in.last && ready_out);
  end
endmodule : uph_mac_model
`default_nettype wire

// >>> tb/uph_props.sv
// checker for the framer ports, bound at the foot.
// assumes one clock and the async reset.
`timescale 1ns/1ps
`default_nettype none
module uph_props
  import uph_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire uph_byte_t rsp_in,
  input wire logic rsp_ready_out,
  input wire uph_byte_t str_in,
  input wire logic str_ready_out,
  input wire uph_byte_t mac_tx_out,
  input wire logic mac_tx_ready_in,
  input wire uph_byte_t mac_rx_in,
  input wire uph_byte_t cmd_out,
  input wire uph_byte_t sdata_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  chk_tx_hold: assert property (mac_tx_out.valid
    && !mac_tx_ready_in |=> $stable(mac_tx_out))
    else $error("tx byte moved in stall");
  // ready drops in the cycle after a byte is taken from either source, so takes are never back to back
  chk_rdy_gap: assert property ((rsp_ready_out && rsp_in.valid)
    || (str_ready_out && str_in.valid)
    |=> !rsp_ready_out && !str_ready_out) else $error("ready too close");
  chk_one_src: assert property (!(rsp_ready_out && str_ready_out))
    else $error("both sources ready");
  chk_rx_cmd: assert property (cmd_out.valid
    |-> $past(mac_rx_in.valid) && cmd_out.data == $past(mac_rx_in.data))
    else $error("cmd byte");
  chk_rx_str: assert property (sdata_out.valid
    |-> $past(mac_rx_in.valid) && sdata_out.data == $past(mac_rx_in.data))
    else $error("str byte");
  chk_rx_last: assert property (cmd_out.valid || sdata_out.valid
    |-> (cmd_out.last || sdata_out.last) == $past(mac_rx_in.last))
    else $error("rx last flag");
  chk_route_one: assert property (
    !(cmd_out.valid && sdata_out.valid))
    else $error("both paths valid");
  chk_rx_drop: assert property (!$past(mac_rx_in.valid)
    |-> !cmd_out.valid && !sdata_out.valid) else $error("byte from idle");
  cov_cmd: cover property (cmd_out.valid);
  cov_str: cover property (sdata_out.valid);
  cov_tx_end: cover property (mac_tx_out.valid && mac_tx_out.last);
endmodule : uph_props
bind uph_packet_header_builder uph_props chk_i (.core_clk_in, .rst_in,
  .rsp_in, .rsp_ready_out, .str_in, .str_ready_out, .mac_tx_out,
  .mac_tx_ready_in, .mac_rx_in, .cmd_out, .sdata_out);
`default_nettype wire

// >>> tb/tb_top.sv
// bench: frames both sources, strips three kinds of frame.
// assumes the mac model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import uph_pkg::*;
  localparam int RP = 18;
  localparam int SP = 515;
  localparam logic [47:0] HM = 48'h0200_0000_0002;
  localparam logic [47:0] DM = 48'h0200_0000_0001;
  // addresses chosen so the response header checksum is 16'hB96B
  localparam logic [31:0] DIP = 32'hC0A8_0002;
  localparam logic [31:0] HIP = 32'hC0A8_0001;
  logic core_clk_in, rst_in, rsp_ready_out, str_ready_out, mac_tx_ready_in;
  uph_byte_t rsp_in, str_in, mac_tx_out, mac_rx_in, cmd_out, sdata_out;
  int seed = 12;
  int errors = 0;
  int compares = 0;
  int np = 0;
  logic [7:0] pq[2][$];
  logic [7:0] eq[$], cq[$], sq[$];
  logic [8:0] gq[$];
  uph_packet_header_builder #(.DEV_MAC(DM), .HOST_MAC(HM), .DEV_IP(DIP),
    .HOST_IP(HIP)) dut (.core_clk_in, .rst_in, .rsp_in, .rsp_ready_out,
    .str_in, .str_ready_out, .mac_tx_out, .mac_tx_ready_in, .mac_rx_in,
    .cmd_out, .sdata_out);
  uph_mac_model mac (.core_clk_in, .rst_in, .tx_in(mac_tx_out),
    .ready_out(mac_tx_ready_in));
  initial
  begin
    core_clk_in = 0;
    forever #2.5 core_clk_in = ~core_clk_in;
  end
  function automatic logic [15:0] csf(int p);
    logic [31:0] x;
    x = 32'h4500 + 28 + p + 32'h4000 + 32'h4011 + DIP[31:16] + DIP[15:0]
      + HIP[31:16] + HIP[15:0];
    x = x[15:0] + x[31:16];
    x = x[15:0] + x[31:16];
    return ~x[15:0];
  endfunction : csf
  function automatic logic [335:0] hdr(int p, bit s);
    logic [15:0] tl, ul;
    tl = 16'(28 + p);
    ul = 16'(8 + p);
    return {HM, DM, 16'h0800, 16'h4500, tl, 16'h0000, 16'h4000, 16'h4011,
      csf(p), DIP, HIP, s ? 16'hDAC0 : 16'hD6D8, s ? 16'h8CA0 : 16'h8C35,
      ul, 16'h0000};
  endfunction : hdr
  task automatic chk(logic [15:0] g, logic [15:0] e);
    compares++;
    if (g !== e)
    begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  always @(posedge core_clk_in)
  begin
    if (mac_tx_out.valid && mac_tx_ready_in)
    begin
      gq.push_back({mac_tx_out.last, mac_tx_out.data});
      if (mac_tx_out.last) np++;
    end
    if (cmd_out.valid) cq.push_back(cmd_out.data);
    if (sdata_out.valid) sq.push_back(sdata_out.data);
    if (rsp_ready_out && rsp_in.valid)
    begin
      pq[0].push_back(rsp_in.data);
      rsp_in.data <= 8'($random(seed));
      if (pq[0].size() == RP) rsp_in.valid <= 1'b0;
    end
    if (str_ready_out && str_in.valid)
    begin
      pq[1].push_back(str_in.data);
      str_in.data <= 8'($random(seed));
      if (pq[1].size() == SP) str_in.valid <= 1'b0;
    end
  end
  task automatic txck(bit s);
    int p;
    logic [335:0] h;
    p = s ? SP : RP;
    h = hdr(p, s);
    for (int t = 0; t < 9000 && np == 0; t++) @(posedge core_clk_in);
    #1;
    chk(16'(np), 16'd1);
    chk(16'(gq.size()), 16'(42 + p));
    chk({gq[24][7:0], gq[25][7:0]}, csf(p));
    chk({gq[40][7:0], gq[41][7:0]}, 16'h0000);
    for (int i = 0; i < 42; i++)
      chk(16'(gq[i]),
        {8'h00, h[335 - 8 * i -: 8]});
    for (int i = 0; i < p; i++)
      chk(16'(gq[42 + i]), 16'({i == p - 1, pq[s][i]}));
    gq.delete();
    pq[s].delete();
    np = 0;
    $display("tx packet from source %0d checked", s);
  endtask : txck
  task automatic rxf(logic [15:0] pt, int n);
    logic [7:0] b;
    @(posedge core_clk_in);
    for (int i = 0; i < 42 + n; i++)
    begin
      b = (i == 36) ? pt[15:8] : (i == 37) ? pt[7:0] : 8'($random(seed));
      if (i >= 42) eq.push_back(b);
      mac_rx_in <= {1'b1, i == 41 + n, b};
      @(posedge core_clk_in);
    end
    mac_rx_in <= '0;
    repeat (3) @(posedge core_clk_in);
    chk(16'(cq.size()), pt == 16'hD6D8 ? 16'(n) : 16'h0000);
    chk(16'(sq.size()), pt == 16'hDAC0 ? 16'(n) : 16'h0000);
    for (int i = 0; i < cq.size(); i++)
      chk(16'(cq[i]), 16'(eq[i]));
    for (int i = 0; i < sq.size(); i++)
      chk(16'(sq[i]), 16'(eq[i]));
    eq.delete();
    cq.delete();
    sq.delete();
    $display("rx frame to port %h checked", pt);
  endtask : rxf
  task report_and_stop;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : report_and_stop
  initial
  begin
    #100000;
    errors++;
    report_and_stop;
  end
  initial
  begin
    rst_in = 1'b1;
    rsp_in = '0;
    str_in = '0;
    mac_rx_in = '0;
    repeat (5) @(posedge core_clk_in);
    rst_in <= 1'b0;
    @(posedge core_clk_in);
    chk(csf(RP), 16'hB96B);
    // both sources at once: the response must go out first
    rsp_in <= {1'b1, 1'b0, 8'h5A};
    str_in <= {1'b1, 1'b0, 8'hA5};
    txck(0);
    txck(1);
    @(posedge core_clk_in);
    rsp_in.valid <= 1'b1;
    txck(0);
    rxf(16'hD6D8, 7);
    rxf(16'hDAC0, 515);
    rxf(16'h1234, 9);
    rxf(16'hD6D8, 7);
    report_and_stop;
  end
endmodule : tb_top
`default_nettype wire
